/* File: wdt_pkg.sv */
// constants, field layout and carrier types of the windowed watchdog
// assumes a single-clock register port and a prescaler of 128 clocks
// Notes on behaviour
// - a 12-bit down counter loads from counter_load_value, mode bits 11..0
// - the counter decrements once every 128 clocks
// - mode resets to 0x3fff2fff: load value 0xfff, fault reset enabled
// - only the first mode write after reset is taken, later writes ignored
// - a mode write reloads and restarts the counter with the new values
// - a valid restart reloads the counter and restarts the prescaler
// - control writes need password 0xa5 in bits 31..24, otherwise dropped
// - underflow sets underflow_flag and raises fault when reset enabled
// - restart while counter above delta sets error flag and fault, even disabled
// - restart while counter at or below delta (bits 27..16) restarts cleanly
// - delta at or above load value allows restart anywhere
// - interrupt follows either flag when fault_interrupt_enable (bit 12) is set
// - fault_reset_enable (bit 13) gates whether a fault requests a reset
// - processor_only_reset (bit 14) picks processor-only or full reset
// - status read or reset clears flags, interrupt and fault
// - a full watchdog reset (bit 14 clear) requests both proc_reset and full_reset, flags stay set until a status read
// - debug_halt (bit 28) stops counting while the processor is in debug
// - idle_halt (bit 29) stops counting while the system is idle
// - guard_disable (bit 15) stops counting but early restarts still fault, clear enables it
// - underflow flag in bit 0, error flag in bit 1, sticky until read
package wdt_pkg;
    localparam logic [3:0]  OFS_CONTROL    = 4'h0;
    localparam logic [3:0]  OFS_MODE       = 4'h4;
    localparam logic [3:0]  OFS_STATUS     = 4'h8;
    localparam logic [31:0] MODE_RESET     = 32'h3fff2fff;
    localparam logic [7:0]  RESTART_KEY    = 8'ha5;
    localparam int          KEY_LSB        = 24;
    localparam int          RESTART_BIT    = 0;
    localparam int          UNF_BIT        = 0;
    localparam int          ERR_BIT        = 1;
    localparam int          PRESCALE_DIV   = 128;
    localparam logic [6:0]  PRESCALE_LAST  = 7'(PRESCALE_DIV - 1);
    localparam logic [11:0] COUNT_ZERO     = 12'h000;

    typedef struct packed {
        logic [1:0]  spare_hi;
        logic        idle_halt;
        logic        debug_halt;
        logic [11:0] restart_window_delta;
        logic        guard_disable;
        logic        processor_only_reset;
        logic        fault_reset_enable;
        logic        fault_interrupt_enable;
        logic [11:0] counter_load_value;
    } mode_t;

    typedef struct packed {
        logic        full_reset;
        logic        proc_reset;
    } reset_req_t;
endpackage

/* File: windowed_watchdog_timer.sv */
// windowed watchdog timer with password restart and write-once mode
// assumes bus strobes and halt inputs are synchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer
    import wdt_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic        debug_state_i,
    input  wire logic        idle_state_i,
    output logic [31:0]      rdata_o,
    output logic             irq_o,
    output logic             fault_o,
    output reset_req_t       reset_req_o
);

////////////////////////////////////////////////////////////////////////////////
// decode

    mode_t       mode_reg;
    logic        mode_locked_reg;
    logic [11:0] count_reg;
    logic [6:0]  presc_reg;
    logic [1:0]  status_reg;
    logic        irq_reg;
    logic        fault_reg;
    reset_req_t  req_reg;
    logic [31:0] rdata_reg;

    logic mode_wr;
    logic restart_wr;
    logic status_rd;
    logic tick;
    logic halted;
    logic in_window;
    logic underflow;
    logic early;

    assign mode_wr    = wr_i && addr_i == OFS_MODE && !mode_locked_reg;
    assign restart_wr = wr_i && addr_i == OFS_CONTROL && wdata_i[RESTART_BIT]
                        && wdata_i[31:KEY_LSB] == RESTART_KEY;
    assign status_rd  = rd_i && addr_i == OFS_STATUS;
    assign halted     = mode_reg.guard_disable
                        || (mode_reg.debug_halt && debug_state_i)
                        || (mode_reg.idle_halt && idle_state_i);
    assign tick       = !halted && presc_reg == PRESCALE_LAST;
    // delta at or above count always lands in window
    assign in_window  = count_reg <= mode_reg.restart_window_delta;
    assign underflow  = tick && count_reg == COUNT_ZERO;
    assign early      = restart_wr && !in_window;

////////////////////////////////////////////////////////////////////////////////
// mode register

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_reg        <= mode_t'(MODE_RESET);
            mode_locked_reg <= 1'b0;
        end else if (mode_wr) begin
            mode_reg        <= mode_t'(wdata_i);
            mode_locked_reg <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// prescaler and counter

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            presc_reg <= 7'h00;
        end else if (mode_wr || (restart_wr && in_window)) begin
            presc_reg <= 7'h00;
        end else if (!halted) begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_reg <= MODE_RESET[11:0];
        end else if (mode_wr) begin
            count_reg <= wdata_i[11:0];
        end else if (restart_wr && in_window) begin
            count_reg <= mode_reg.counter_load_value;
        end else if (underflow) begin
            count_reg <= mode_reg.counter_load_value;
        end else if (tick) begin
            count_reg <= count_reg - 12'h001;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// status flags, interrupt, fault

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= 2'b00;
        end else begin
            // set beats the clearing read
            status_reg[UNF_BIT] <= underflow || (status_reg[UNF_BIT] && !status_rd);
            status_reg[ERR_BIT] <= early || (status_reg[ERR_BIT] && !status_rd);
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= mode_reg.fault_interrupt_enable
                       && (underflow || early
                           || ((status_reg != 2'b00) && !status_rd));
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fault_reg <= 1'b0;
        end else if ((underflow && mode_reg.fault_reset_enable) || early) begin
            fault_reg <= 1'b1;
        end else if (status_rd) begin
            fault_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            req_reg <= '0;
        end else if (((underflow || early) && mode_reg.fault_reset_enable)
                     || (fault_reg && mode_reg.fault_reset_enable && !status_rd)) begin
            req_reg.proc_reset <= 1'b1;
            req_reg.full_reset <= !mode_reg.processor_only_reset;
        end else begin
            req_reg <= '0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// read port

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_reg <= 32'h00000000;
        end else if (rd_i && addr_i == OFS_MODE) begin
            rdata_reg <= mode_reg;
        end else if (status_rd) begin
            rdata_reg <= {30'h00000000, status_reg};
        end else begin
            rdata_reg <= 32'h00000000;
        end
    end

    assign rdata_o     = rdata_reg;
    assign irq_o       = irq_reg;
    assign fault_o     = fault_reg;
    assign reset_req_o = req_reg;

////////////////////////////////////////////////////////////////////////////////
// checks

    chk_mode_once: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mode_locked_reg |=> $stable(mode_reg))
        else $error("mode changed after lock");

    chk_key_guard: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (wr_i && addr_i == OFS_CONTROL && wdata_i[31:24] != 8'ha5 && !tick)
        |=> $stable(count_reg) && !status_reg[ERR_BIT] || $past(status_reg[ERR_BIT]))
        else $error("bad key acted");

    chk_restart_load: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (restart_wr && in_window && !mode_wr)
        |=> count_reg == $past(mode_reg.counter_load_value) && presc_reg == 7'h00)
        else $error("restart did not reload");

    chk_early_err: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        early |=> status_reg[ERR_BIT] && fault_o)
        else $error("early restart not flagged");

    chk_unf_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        underflow |=> status_reg[UNF_BIT])
        else $error("underflow not flagged");

    chk_read_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (status_rd && !underflow && !early) |=> status_reg == 2'b00 && !fault_o)
        else $error("read did not clear");

    chk_irq_mask: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !mode_reg.fault_interrupt_enable && $stable(mode_reg) |=> !irq_o)
        else $error("irq while masked");

    chk_halt_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (mode_reg.guard_disable && !restart_wr && !mode_wr) |=> $stable(count_reg))
        else $error("counted while disabled");

    chk_tick_rate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        tick |=> !tick [*8])
        else $error("ticks too close");

    chk_no_reset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !mode_reg.fault_reset_enable && $stable(mode_reg) |=> reset_req_o == '0)
        else $error("reset request while disabled");

    chk_mode_reload: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mode_wr |=> count_reg == $past(wdata_i[11:0]) && presc_reg == 7'h00)
        else $error("mode write did not reload");

    chk_window_clean: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (restart_wr && in_window && !status_reg[ERR_BIT]) |=> !status_reg[ERR_BIT])
        else $error("restart in window flagged");

    chk_debug_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (mode_reg.debug_halt && debug_state_i && !restart_wr && !mode_wr)
        |=> $stable(count_reg) && $stable(presc_reg))
        else $error("counted in debug");

    chk_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (mode_reg.idle_halt && idle_state_i && !restart_wr && !mode_wr)
        |=> $stable(count_reg) && $stable(presc_reg))
        else $error("counted while idle");

    chk_proc_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (fault_reg && mode_reg.fault_reset_enable && mode_reg.processor_only_reset
         && !status_rd)
        |=> reset_req_o.proc_reset && !reset_req_o.full_reset)
        else $error("wrong reset kind");

    chk_irq_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (mode_reg.fault_interrupt_enable && status_reg != 2'b00 && !status_rd) |=> irq_o)
        else $error("interrupt dropped while flagged");

endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the windowed watchdog timer
// assumes reads answer one cycle after the strobe, single clock
`timescale 1ns/1ps
`default_nettype none
module tb;
    import wdt_pkg::*;
    logic        clk_sys_i     = 1'b0;
    logic        resetn_i      = 1'b0;
    logic [3:0]  addr_i        = 4'h0;
    logic [31:0] wdata_i       = 32'h0;
    logic        wr_i          = 1'b0;
    logic        rd_i          = 1'b0;
    logic        debug_state_i = 1'b0;
    logic        idle_state_i  = 1'b0;
    logic [31:0] rdata_o;
    logic        irq_o;
    logic        fault_o;
    reset_req_t  reset_req_o;
    logic [31:0] rd_val;
    logic [31:0] cfg_mode [3] = '{32'h00002001, 32'h0000b001, 32'h00001001};
    logic [1:0]  cfg_req  [3] = '{2'b11, 2'b11, 2'b00};
    logic        cfg_irq  [3] = '{1'b0, 1'b1, 1'b1};
    logic        cfg_unf  [3] = '{1'b1, 1'b0, 1'b0};
    int          err_total   = 0;
    int          check_count = 0;

    windowed_watchdog_timer dut_u (.clk_sys_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .debug_state_i, .idle_state_i, .rdata_o, .irq_o, .fault_o, .reset_req_o);

    always #2.5 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////////////
    task results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge clk_sys_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        rd_val = rdata_o;
    endtask

    task wait_fault(input int n);
        int i;
        for (i = 0; i < n && fault_o !== 1'b1; i++) begin
            cyc(1);
        end
        if (fault_o !== 1'b1) begin
            err_total++;
            $display("ERROR at %0t: fault never rose", $time);
            results();
        end
    endtask

    task phase(input int k);
        resetn_i <= 1'b0;
        cyc(2);
        resetn_i <= 1'b1;
        cyc(1);
        rd(OFS_STATUS);
        chk(rd_val, 32'h0);
        wr(OFS_MODE, cfg_mode[k]);
        wr(OFS_CONTROL, 32'ha5000001);
        cyc(3);
        chk(32'(fault_o), 32'h1);
        chk(32'(reset_req_o), 32'(cfg_req[k]));
        chk(32'(irq_o), 32'(cfg_irq[k]));
        rd(OFS_STATUS);
        chk(rd_val, 32'h2);
        cyc(1);
        chk(32'(fault_o), 32'h0);
        cyc(600);
        chk(32'(fault_o), 32'(cfg_unf[k]));
        $display("config test %0d done", k);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(2);
        resetn_i <= 1'b1;
        cyc(1);
        rd(OFS_MODE);
        chk(rd_val, MODE_RESET);
        rd(OFS_STATUS);
        chk(rd_val, 32'h0);
        wr(OFS_CONTROL, 32'ha5000001);
        cyc(2);
        chk(32'(fault_o), 32'h0);
        wr(OFS_MODE, 32'h30017002);
        wr(OFS_MODE, 32'h00000fff);
        rd(OFS_MODE);
        chk(rd_val, 32'h30017002);
        wr(OFS_CONTROL, 32'h5a000001);
        cyc(2);
        chk(32'(fault_o), 32'h0);
        wr(OFS_CONTROL, 32'ha5000001);
        cyc(3);
        chk(32'(fault_o), 32'h1);
        chk(32'(irq_o), 32'h1);
        chk(32'(reset_req_o), 32'h1);
        rd(OFS_STATUS);
        chk(rd_val, 32'h2);
        cyc(1);
        chk(32'(irq_o), 32'h0);
        $display("window test done");
        cyc(270);
        wr(OFS_CONTROL, 32'ha5000001);
        cyc(370);
        chk(32'(fault_o), 32'h0);
        wait_fault(20);
        rd(OFS_STATUS);
        chk(rd_val, 32'h1);
        debug_state_i <= 1'b1;
        cyc(800);
        chk(32'(fault_o), 32'h0);
        debug_state_i <= 1'b0;
        idle_state_i  <= 1'b1;
        cyc(800);
        chk(32'(fault_o), 32'h0);
        idle_state_i  <= 1'b0;
        wait_fault(400);
        $display("underflow and halt test done");
        for (int k = 0; k < 3; k++) begin
            phase(k);
        end
        results();
    end
endmodule
`default_nettype wire
